/* File: src/pwiu_context.sv */
// single-level interrupt stack and shadow registers
`timescale 1ns/100ps
`default_nettype none
module pwiu_context (
  input  wire logic clk,
  input  wire logic rst,
  pwiu_ctx_if.store ctx
);
  // one level only: a second save before a restore would overwrite it,
  // which the sequencer prevents by refusing entry inside a handler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctx.s_pc     <= '0;
      ctx.s_bank   <= '0;
      ctx.s_status <= '0;
      ctx.s_mode   <= '0;
      ctx.s_w      <= '0;
    end else if (ctx.save) begin
      ctx.s_pc     <= ctx.pc; // RULE_14
      ctx.s_bank   <= ctx.bank;
      ctx.s_status <= ctx.status;
      ctx.s_mode   <= ctx.mode;
      ctx.s_w      <= ctx.w;
    end
  end
endmodule
`default_nettype wire

/* File: src/pwiu_ctx_if.sv */
// context save and restore signals between sequencer and shadow store
`timescale 1ns/100ps
`default_nettype none
interface pwiu_ctx_if
  import pwiu_pkg::*;
#(
  parameter int PC_W = 12
);
  logic            save;
  logic [PC_W-1:0] pc;
  pwiu_byte_t      bank;
  pwiu_byte_t      status;
  pwiu_byte_t      mode;
  pwiu_byte_t      w;
  logic [PC_W-1:0] s_pc;
  pwiu_byte_t      s_bank;
  pwiu_byte_t      s_status;
  pwiu_byte_t      s_mode;
  pwiu_byte_t      s_w;

  modport ctl   (output save, pc, bank, status, mode, w,
                 input  s_pc, s_bank, s_status, s_mode, s_w);
  modport store (input  save, pc, bank, status, mode, w,
                 output s_pc, s_bank, s_status, s_mode, s_w);
endinterface
`default_nettype wire

/* File: src/pwiu_edge_bit.sv */
// one pin: synchroniser, previous sample and selected-edge detector
`timescale 1ns/100ps
`default_nettype none
`include "pwiu_params.svh"
module pwiu_edge_bit (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_raw,
  input  wire logic fall_sel,
  output logic      edge_hit
);
  logic                       meta_q;
  logic                       sync_q;
  logic                       prev_q;
  logic [`PWIU_SYNC_FILL-1:0] fill_q;

  // fill_q keeps the reset value of prev_q from looking like an edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      fill_q <= '0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q; // RULE_23
      fill_q <= {fill_q[`PWIU_SYNC_FILL-2:0], 1'b1};
    end
  end

  wire logic fall_seen = prev_q & ~sync_q;
  wire logic rise_seen = ~prev_q & sync_q;
  assign edge_hit = fill_q[`PWIU_SYNC_FILL-1] & (fall_sel ? fall_seen : rise_seen); // RULE_02
endmodule
`default_nettype wire

/* File: src/pwiu_params.svh */
// constants for the port wakeup and interrupt unit
// Function
// RULE_01 - a cleared enable bit lets its pin wake or interrupt; a set bit blocks it
// RULE_02 - a set edge-select bit picks falling edges, a cleared bit rising edges
// RULE_03 - reset loads enable and edge-select registers with all ones
// RULE_04 - a selected pin edge sets its pending bit, held until software clears it
// RULE_05 - the pending register has no reset value
// RULE_06 - software programs edges, clears pending, then clears enable bits last
// RULE_07 - a pin wakeup from power-down loads the top program address
// RULE_08 - port-control writes swap W with pending or comparator, else plain move
// RULE_09 - outside power-down the eight pins act as edge interrupt sources
// RULE_10 - counter rollover raises an interrupt gated by its option enable bit
// RULE_11 - each multifunction timer gives overflow, compare and capture interrupts
// RULE_12 - all sources have equal priority and are taken one at a time
// RULE_13 - after acknowledge no interrupt is entered until the return instruction
// RULE_14 - entry pushes PC on a private stack and shadows bank, status, mode, W
// RULE_15 - page select bits of status are cleared after status is shadowed
// RULE_16 - the handler starts at program address zero
// RULE_17 - the handler polls all pending flags and clears the serviced one
// RULE_18 - pin handlers clear the serviced pending bit so the pin can retrigger
// RULE_19 - return pops PC, restores shadows and re-enables interrupt acceptance
// RULE_20 - the alternate return also adds W to the real-time counter
// RULE_21 - a pin edge inside a handler pends at once and is taken after return
// RULE_22 - timer events inside a handler produce no interrupt
// RULE_23 - pins are sampled every clock and compared with the previous sample
`ifndef PWIU_PARAMS_SVH
`define PWIU_PARAMS_SVH

`define PWIU_NPINS        8
`define PWIU_NTMR_SRC     6
`define PWIU_PC_W         12
`define PWIU_EN_RST       8'hFF
`define PWIU_EDGE_RST     8'hFF
`define PWIU_MODE_PEND    8'h19
`define PWIU_MODE_PEND2   8'h09
`define PWIU_MODE_CMP     8'h18
`define PWIU_MODE_EDGE    8'h1A
`define PWIU_MODE_EN      8'h1B
`define PWIU_PAGE_MASK    8'hE0
`define PWIU_SYNC_FILL    3

`endif

/* File: src/pwiu_pkg.sv */
// types shared by the port wakeup and interrupt unit
package pwiu_pkg;
  typedef logic [7:0] pwiu_byte_t;
  typedef enum logic {PWIU_IDLE, PWIU_ISR} pwiu_state_t;
endpackage

/* File: src/pwiu_top.sv */
// port wakeup, pin interrupt and interrupt entry/return sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pwiu_params.svh"
module pwiu_top
  import pwiu_pkg::*;
#(
  parameter int PC_W = `PWIU_PC_W
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [`PWIU_NPINS-1:0]   port_pins,
  input  wire logic                     sleep_mode,
  input  wire logic                     insn_boundary,
  input  wire logic                     ret_int,
  input  wire logic                     ret_add_w,
  input  wire logic                     port_ctl_wr,
  input  wire pwiu_byte_t               mode_sel,
  input  wire pwiu_byte_t               w_in,
  input  wire pwiu_byte_t               cmp_rd_data,
  input  wire logic [PC_W-1:0]          pc_in,
  input  wire pwiu_byte_t               bank_in,
  input  wire pwiu_byte_t               status_in,
  input  wire pwiu_byte_t               mode_in,
  input  wire logic                     rtc_roll,
  input  wire logic                     rtc_int_en,
  input  wire logic [`PWIU_NTMR_SRC-1:0] tmr_evt,
  input  wire logic [`PWIU_NTMR_SRC-1:0] tmr_evt_en,
  output pwiu_byte_t                    pin_wake_enable_q,
  output pwiu_byte_t                    pin_wake_edge_select_q,
  output pwiu_byte_t                    pin_wake_pending_q,
  output logic                          wake_q,
  output logic                          int_ack_q,
  output logic                          in_isr_q,
  output logic                          pc_load_q,
  output logic [PC_W-1:0]               pc_val_q,
  output logic                          status_load_q,
  output pwiu_byte_t                    status_val_q,
  output logic                          ctx_load_q,
  output pwiu_byte_t                    bank_val_q,
  output pwiu_byte_t                    mode_val_q,
  output logic                          w_load_q,
  output pwiu_byte_t                    w_val_q,
  output logic                          cmp_wr_q,
  output pwiu_byte_t                    cmp_wdata_q,
  output logic                          rtc_add_q,
  output pwiu_byte_t                    rtc_add_val_q,
  output logic                          rtc_flag_q
);
  pwiu_state_t                 state_q;
  pwiu_state_t                 state_d;
  logic                        tmr_req_q;
  logic                        tmr_req_d;
  logic                        pend_seen_q;
  pwiu_byte_t                  pend_d;
  wire logic [`PWIU_NPINS-1:0] pin_edge;

  pwiu_ctx_if #(.PC_W(PC_W)) ctx ();

  pwiu_context u_ctx (
    .clk (clk),
    .rst (rst),
    .ctx (ctx)
  );

  for (genvar i = 0; i < `PWIU_NPINS; i++) begin : g_pin
    pwiu_edge_bit u_edge (
      .clk      (clk),
      .rst      (rst),
      .pin_raw  (port_pins[i]),
      .fall_sel (pin_wake_edge_select_q[i]),
      .edge_hit (pin_edge[i])
    );
  end

  // port-control write decode by mode selector
  wire logic wr_pend = port_ctl_wr &&
                       (mode_sel == `PWIU_MODE_PEND || mode_sel == `PWIU_MODE_PEND2);
  wire logic wr_cmp  = port_ctl_wr && (mode_sel == `PWIU_MODE_CMP);
  wire logic wr_edge = port_ctl_wr && (mode_sel == `PWIU_MODE_EDGE);
  wire logic wr_en   = port_ctl_wr && (mode_sel == `PWIU_MODE_EN);

  // a set bit in the enable register masks the pin
  wire pwiu_byte_t pin_live = pin_wake_pending_q & ~pin_wake_enable_q; // RULE_01
  wire logic pin_req  = !sleep_mode && (|pin_live); // RULE_09 RULE_21
  wire logic wake_hit = sleep_mode && (|(pin_edge & ~pin_wake_enable_q));
  wire logic tmr_hit  = (rtc_roll && rtc_int_en) || (|(tmr_evt & tmr_evt_en)); // RULE_10 RULE_11
  wire logic idle     = (state_q == PWIU_IDLE);
  // every source feeds one request; no source outranks another
  wire logic take     = idle && insn_boundary && !sleep_mode && (pin_req || tmr_req_q); // RULE_12
  wire logic leave    = !idle && ret_int;

  // software write and hardware set in the same cycle: the set wins
  assign pend_d = (wr_pend ? w_in : pin_wake_pending_q) | pin_edge; // RULE_04

  // timer events seen inside a handler are dropped, not deferred
  assign tmr_req_d = (tmr_req_q && !take) || (tmr_hit && idle); // RULE_22

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PWIU_IDLE: begin
        if (take) begin
          state_d = PWIU_ISR;
        end
      end
      PWIU_ISR: begin
        if (ret_int) begin
          state_d = PWIU_IDLE; // RULE_13 RULE_19
        end
      end
    endcase
  end

  // output value selection
  wire logic [PC_W-1:0] pc_sel = wake_hit ? {PC_W{1'b1}} : // RULE_07
                                 take ? '0 :                // RULE_16
                                 ctx.s_pc;
  wire pwiu_byte_t status_sel = take ? (status_in & ~`PWIU_PAGE_MASK) : ctx.s_status; // RULE_15
  wire pwiu_byte_t w_sel = leave ? ctx.s_w : wr_pend ? pin_wake_pending_q : cmp_rd_data; // RULE_08

  assign ctx.save   = take; // RULE_14
  assign ctx.pc     = pc_in;
  assign ctx.bank   = bank_in;
  assign ctx.status = status_in;
  assign ctx.mode   = mode_in;
  assign ctx.w      = w_in;

  // no reset: contents are arbitrary until software clears them
  always_ff @(posedge clk) begin
    pin_wake_pending_q <= pend_d; // RULE_05
  end

  // pending has no reset value, so checks on it wait for the first software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_seen_q <= 1'b0;
    end else if (wr_pend) begin
      pend_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_wake_enable_q      <= `PWIU_EN_RST;   // RULE_03
      pin_wake_edge_select_q <= `PWIU_EDGE_RST; // RULE_03
    end else begin
      if (wr_en) pin_wake_enable_q <= w_in;
      if (wr_edge) pin_wake_edge_select_q <= w_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= PWIU_IDLE;
      in_isr_q  <= 1'b0;
      tmr_req_q <= 1'b0;
      int_ack_q <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      in_isr_q  <= (state_d == PWIU_ISR);
      tmr_req_q <= tmr_req_d;
      int_ack_q <= take;
      wake_q    <= wake_hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_load_q     <= 1'b0;
      pc_val_q      <= '0;
      status_load_q <= 1'b0;
      status_val_q  <= '0;
      ctx_load_q    <= 1'b0;
      bank_val_q    <= '0;
      mode_val_q    <= '0;
    end else begin
      pc_load_q     <= take || leave || wake_hit;
      pc_val_q      <= pc_sel;
      status_load_q <= take || leave;
      status_val_q  <= status_sel;
      ctx_load_q    <= leave; // RULE_19
      bank_val_q    <= ctx.s_bank;
      mode_val_q    <= ctx.s_mode;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_load_q      <= 1'b0;
      w_val_q       <= '0;
      cmp_wr_q      <= 1'b0;
      cmp_wdata_q   <= '0;
      rtc_add_q     <= 1'b0;
      rtc_add_val_q <= '0;
      rtc_flag_q    <= 1'b0;
    end else begin
      w_load_q      <= leave || wr_pend || wr_cmp; // RULE_08
      w_val_q       <= w_sel;
      cmp_wr_q      <= wr_cmp;
      cmp_wdata_q   <= w_in;
      rtc_add_q     <= leave && ret_add_w; // RULE_20
      rtc_add_val_q <= w_in;
      rtc_flag_q    <= rtc_roll; // RULE_10
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_EDGE_PENDS: assert property ( // RULE_04
    (|pin_edge) |=> ((pin_wake_pending_q & $past(pin_edge)) == $past(pin_edge)))
    else $error("pin edge did not set pending bit");

  AST_PEND_HOLDS: assert property ( // RULE_04
    (pend_seen_q && !wr_pend && !(|pin_edge)) |=> $stable(pin_wake_pending_q))
    else $error("pending changed without edge or write");

  AST_MASKED_NO_ACK: assert property ( // RULE_01
    (idle && !tmr_req_q && pin_live == '0) |=> !int_ack_q)
    else $error("interrupt taken with all pins masked");

  AST_ENTRY_VECTOR: assert property ( // RULE_16
    int_ack_q |-> (pc_load_q && pc_val_q == '0 && in_isr_q))
    else $error("entry did not load vector zero");

  AST_NO_NESTING: assert property ( // RULE_13
    (in_isr_q && !ret_int) |=> (!int_ack_q && in_isr_q))
    else $error("nested entry or lost handler state");

  AST_PAGE_CLEAR: assert property ( // RULE_15
    take |=> (status_load_q && (status_val_q & `PWIU_PAGE_MASK) == '0
              && ctx.s_status == $past(status_in)))
    else $error("page bits not cleared after shadow");

  AST_WAKE_VECTOR: assert property ( // RULE_07
    wake_q |-> (pc_load_q && pc_val_q == {PC_W{1'b1}}))
    else $error("wakeup did not load top address");

  AST_RETURN_RESTORE: assert property ( // RULE_19
    (in_isr_q && ret_int) |=> (ctx_load_q && !in_isr_q && pc_val_q == ctx.s_pc
                               && w_val_q == ctx.s_w))
    else $error("return did not restore context");

  AST_SWAP_PEND: assert property ( // RULE_08
    (wr_pend && pend_seen_q) |=> (w_load_q && w_val_q == $past(pin_wake_pending_q)))
    else $error("pending swap returned wrong value");

  AST_TMR_IN_ISR: assert property ( // RULE_22
    (in_isr_q && !tmr_req_q) |=> !tmr_req_q)
    else $error("timer event inside handler was kept");

  AST_RETW_ADD: assert property ( // RULE_20
    (in_isr_q && ret_int && ret_add_w) |=> (rtc_add_q && rtc_add_val_q == $past(w_in)))
    else $error("alternate return did not add W");

  AST_EN_WRITE: assert property ( // RULE_01
    wr_en |=> (pin_wake_enable_q == $past(w_in)))
    else $error("enable register write lost");

  AST_EDGE_WRITE: assert property ( // RULE_02
    wr_edge |=> (pin_wake_edge_select_q == $past(w_in)))
    else $error("edge select register write lost");

  AST_CMP_SWAP: assert property ( // RULE_08
    (wr_cmp && !leave) |=> (cmp_wr_q && w_load_q && cmp_wdata_q == $past(w_in)
                            && w_val_q == $past(cmp_rd_data)))
    else $error("comparator swap returned wrong value");

  AST_PLAIN_MOVE: assert property ( // RULE_08
    (port_ctl_wr && !wr_pend && !wr_cmp && !leave) |=> !w_load_q)
    else $error("plain move loaded W");

  AST_SLEEP_NO_ENTRY: assert property ( // RULE_09
    sleep_mode |=> !int_ack_q)
    else $error("interrupt entered in power-down");

  AST_WAKE_MASKED: assert property ( // RULE_01
    (sleep_mode && (pin_edge & ~pin_wake_enable_q) == '0) |=> !wake_q)
    else $error("wakeup from masked or quiet pin");

  AST_ENTRY_SAVE: assert property ( // RULE_14
    take |=> (ctx.s_pc == $past(pc_in) && ctx.s_bank == $past(bank_in)
              && ctx.s_mode == $past(mode_in) && ctx.s_w == $past(w_in)))
    else $error("entry did not shadow context");

  AST_TMR_KEPT: assert property ( // RULE_11
    (idle && tmr_hit) |=> tmr_req_q)
    else $error("timer event while idle was lost");

  AST_RTC_FLAG: assert property ( // RULE_10
    rtc_roll |=> rtc_flag_q)
    else $error("rollover did not raise counter flag");

  AST_RET_PLAIN: assert property ( // RULE_20
    (in_isr_q && ret_int && !ret_add_w) |=> !rtc_add_q)
    else $error("plain return added W to counter");

  AST_PIN_AFTER_RET: assert property ( // RULE_21
    (in_isr_q && ret_int && pin_req) ##1 (insn_boundary && pin_req && !sleep_mode)
      |=> int_ack_q)
    else $error("pending pin not taken after return");

  COV_PIN_INT: cover property (int_ack_q ##[1:50] (in_isr_q && ret_int));
  COV_WAKE: cover property (sleep_mode ##1 wake_q);
  COV_TMR_INT: cover property (tmr_hit && idle ##[1:10] int_ack_q);
  COV_RETW: cover property (rtc_add_q);
endmodule
`default_nettype wire

/* File: verif/pwiu_core_model.sv */
// core-side model: offers entry every cycle and returns a set delay after acknowledge
`timescale 1ns/100ps
`default_nettype none
module pwiu_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       int_ack_q,
  input  wire logic [7:0] hold,
  input  wire logic       add_w,
  output logic            insn_boundary,
  output logic            ret_int,
  output var logic        ret_add_w
);
  logic [7:0] cnt_q;
  logic       busy_q;
  wire        fin = busy_q && (cnt_q == hold);

  assign insn_boundary = 1'b1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      ret_int <= 1'b0;
      ret_add_w <= 1'b0;
    end else begin
      ret_int <= fin;
      // qualifier is driven to the inverse of add_w outside returns so it is never a stale match
      ret_add_w <= fin ? add_w : ~add_w;
      cnt_q <= int_ack_q ? 8'h00 : cnt_q + 8'h01;
      busy_q <= int_ack_q | (busy_q & ~fin);
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// testbench for the port wakeup and interrupt unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pwiu_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sleep_mode = 1'b0, port_ctl_wr = 1'b0, add_w = 1'b0;
  logic rtc_roll = 1'b0, rtc_int_en = 1'b0, insn_boundary, ret_int, ret_add_w;
  logic [7:0] port_pins = 8'h0F;
  logic [5:0] tmr_evt = 6'h00, tmr_evt_en = 6'h00;
  logic [11:0] pc_in = 12'h000, pc_val_q, l_pc;
  pwiu_byte_t mode_sel = 8'h00, w_in = 8'h00, cmp_rd_data = 8'h6C, bank_in = 8'h00;
  pwiu_byte_t status_in = 8'h00, mode_in = 8'h00;
  pwiu_byte_t pin_wake_enable_q, pin_wake_edge_select_q, pin_wake_pending_q;
  pwiu_byte_t status_val_q, bank_val_q, mode_val_q, w_val_q, cmp_wdata_q, rtc_add_val_q;
  pwiu_byte_t l_st, l_bk, l_md, l_w, l_cmp, l_add;
  logic wake_q, int_ack_q, in_isr_q, pc_load_q, status_load_q, ctx_load_q, w_load_q;
  logic cmp_wr_q, rtc_add_q, rtc_flag_q;
  int   error_cnt = 0, n_compared = 0, cyc = 0, i;
  int   ack_n = 0, w_n = 0, wake_n = 0, add_n = 0, flag_n = 0;

  pwiu_top i_dut (.clk, .rst, .port_pins, .sleep_mode, .insn_boundary, .ret_int, .ret_add_w,
    .port_ctl_wr, .mode_sel, .w_in, .cmp_rd_data, .pc_in, .bank_in, .status_in, .mode_in,
    .rtc_roll, .rtc_int_en, .tmr_evt, .tmr_evt_en, .pin_wake_enable_q, .pin_wake_edge_select_q,
    .pin_wake_pending_q, .wake_q, .int_ack_q, .in_isr_q, .pc_load_q, .pc_val_q, .status_load_q,
    .status_val_q, .ctx_load_q, .bank_val_q, .mode_val_q, .w_load_q, .w_val_q, .cmp_wr_q,
    .cmp_wdata_q, .rtc_add_q, .rtc_add_val_q, .rtc_flag_q);
  pwiu_core_model i_core (.clk, .rst, .int_ack_q, .hold(8'h28), .add_w, .insn_boundary,
    .ret_int, .ret_add_w);

  initial begin
    forever #2 clk = ~clk;
  end

  // pulses are caught in the cycle they stand, then judged later
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (int_ack_q === 1'b1) ack_n <= ack_n + 1;
    if (w_load_q === 1'b1) w_n <= w_n + 1;
    if (wake_q === 1'b1) wake_n <= wake_n + 1;
    if (rtc_flag_q === 1'b1) flag_n <= flag_n + 1;
    if (rtc_add_q === 1'b1) add_n <= add_n + 1;
    if (rtc_add_q === 1'b1) l_add <= rtc_add_val_q;
    if (pc_load_q === 1'b1) l_pc <= pc_val_q;
    if (status_load_q === 1'b1) l_st <= status_val_q;
    if (ctx_load_q === 1'b1) {l_bk, l_md} <= {bank_val_q, mode_val_q};
    if (w_load_q === 1'b1) l_w <= w_val_q;
    if (cmp_wr_q === 1'b1) l_cmp <= cmp_wdata_q;
    if (cyc == 8000) begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input pwiu_byte_t m, input pwiu_byte_t w);
    @(posedge clk);
    port_ctl_wr <= 1'b1;
    mode_sel <= m;
    w_in <= w;
    @(posedge clk);
    port_ctl_wr <= 1'b0;
    tk(1);
  endtask

  // pins settle through two flops and a compare before the flag sets
  task automatic pins(input logic [7:0] v);
    @(posedge clk);
    port_pins <= v;
    tk(8);
  endtask

  task automatic wisr(input logic lvl);
    for (int k = 0; k < 200 && in_isr_q !== lvl; k++) @(negedge clk);
    chk(16'(in_isr_q), 16'(lvl));
    tk(1);
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tk(4);
    chk(16'({pin_wake_enable_q, pin_wake_edge_select_q}), 16'hFFFF);
    wr(8'h1A, 8'h0F);
    wr(8'h19, 8'h00);
    wr(8'h1B, 8'hFF);
    chk(16'({pin_wake_edge_select_q, pin_wake_pending_q}), 16'h0F00);
    pins(8'h1F);
    pins(8'h1E);
    pins(8'h1F);
    pins(8'h0F);
    chk(16'(pin_wake_pending_q), 16'h0011);
    chk(16'(ack_n), 16'h0000);
    wr(8'h09, 8'h00);
    chk(16'(l_w), 16'h0011);
    wr(8'h19, 8'h80);
    wr(8'h19, 8'h00);
    chk(16'({l_w, pin_wake_pending_q}), 16'h8000);
    wr(8'h18, 8'h93);
    chk(16'({l_cmp, l_w}), 16'h936C);
    wr(8'h1C, 8'h55);
    chk(16'(w_n), 16'h0005);
    tend("registers");
    wr(8'h1B, 8'hFC);
    @(posedge clk);
    {pc_in, status_in, bank_in, mode_in} <= {12'h234, 8'hE5, 8'h3C, 8'h1F};
    pins(8'h0E);
    wisr(1'b1);
    chk(16'({ack_n[7:0], l_st}), 16'h0105);
    chk(16'(l_pc), 16'h0000);
    @(posedge clk);
    {pc_in, status_in, bank_in, mode_in} <= {12'h0AB, 8'h00, 8'h00, 8'h00};
    pins(8'h0C);
    chk(16'({ack_n[7:0], pin_wake_pending_q}), 16'h0103);
    wr(8'h19, 8'h02);
    wisr(1'b0);
    chk(16'(l_pc), 16'h0234);
    chk(16'({l_bk, l_md}), 16'h3C1F);
    chk(16'({l_st, l_w}), 16'hE5FC);
    wisr(1'b1);
    chk(16'({ack_n[7:0], add_n[7:0]}), 16'h0200);
    wr(8'h19, 8'h00);
    @(posedge clk);
    w_in <= 8'h33;
    add_w <= 1'b1;
    wisr(1'b0);
    chk(16'(l_add), 16'h0033);
    tk(10);
    chk(16'(ack_n), 16'h0002);
    tend("pin interrupt");
    @(posedge clk);
    tmr_evt_en <= 6'h3F;
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      tmr_evt <= 6'(1 << i);
      @(posedge clk);
      tmr_evt <= 6'h00;
      wisr(1'b1);
      @(posedge clk);
      tmr_evt <= 6'h02;
      @(posedge clk);
      tmr_evt <= 6'h00;
      wisr(1'b0);
      tk(6);
      chk(16'(ack_n), 16'(3 + i));
    end
    @(posedge clk);
    tmr_evt_en <= 6'h00;
    tmr_evt <= 6'h3F;
    rtc_roll <= 1'b1;
    @(posedge clk);
    {tmr_evt, rtc_roll} <= 7'h00;
    tk(8);
    chk(16'({ack_n[7:0], flag_n[7:0]}), 16'h0801);
    @(posedge clk);
    rtc_int_en <= 1'b1;
    rtc_roll <= 1'b1;
    @(posedge clk);
    rtc_roll <= 1'b0;
    wisr(1'b1);
    wisr(1'b0);
    chk(16'({ack_n[7:0], flag_n[7:0]}), 16'h0902);
    tend("timers");
    @(posedge clk);
    sleep_mode <= 1'b1;
    pins(8'h1E);
    chk(16'(wake_n), 16'h0000);
    pins(8'h1C);
    chk(16'({wake_n[3:0], l_pc}), 16'h1FFF);
    wr(8'h19, 8'h00);
    @(posedge clk);
    sleep_mode <= 1'b0;
    tk(8);
    chk(16'(ack_n), 16'h0009);
    tend("wakeup");
    stop_test();
  end
endmodule
`default_nettype wire
